// ### inc/tsc_pkg.sv
// constants for the termination strength control block
package tsc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the ahb-lite slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] TSC_REG_MODE0  = 8'h00;  // power-down dll control
  localparam logic [7:0] TSC_REG_MODE1  = 8'h04;  // nominal strength code
  localparam logic [7:0] TSC_REG_MODE2  = 8'h08;  // write strength code
  localparam logic [7:0] TSC_REG_LAT    = 8'h0c;  // write and additive latency
  localparam logic [7:0] TSC_REG_STATUS = 8'h10;  // live termination state

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int TSC_PD_DLL_BIT  = 0;   // mode0: 1 keeps dll on in power-down
  localparam int TSC_NOM_LSB     = 0;   // mode1: {a9,a6,a2}
  localparam int TSC_NOM_W       = 3;
  localparam int TSC_WR_LSB      = 0;   // mode2: {a10,a9}
  localparam int TSC_WR_W        = 2;
  localparam int TSC_CWL_LSB     = 0;   // lat: write latency without additive part
  localparam int TSC_AL_LSB      = 8;   // lat: additive latency
  localparam int TSC_LAT_W       = 5;
  localparam int TSC_ST_ON_BIT   = 0;   // status: termination switched on
  localparam int TSC_ST_WSTR_BIT = 1;   // status: write strength selected
  localparam int TSC_ST_ASYNC    = 2;   // status: asynchronous mode active
  localparam int TSC_ST_DYN_BIT  = 3;   // status: dynamic switching enabled
  localparam int TSC_ST_CODE_LSB = 4;   // status: applied strength code

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic           TSC_RST_PD_DLL = 1'b0;
  localparam logic [2:0]     TSC_RST_NOM    = 3'h0;
  localparam logic [1:0]     TSC_RST_WR     = 2'h0;
  localparam logic [4:0]     TSC_RST_CWL    = 5'h05;
  localparam logic [4:0]     TSC_RST_AL     = 5'h00;

  // ----------------------------------------------------------------
  // latencies and times
  // ----------------------------------------------------------------
  localparam logic [5:0] TSC_LAT_OFFSET  = 6'h02;  // on/off latency = cwl + al - 2
  localparam logic [2:0] TSC_CHOP4_EXTRA = 3'h4;   // back to nominal at off latency + 4
  localparam logic [2:0] TSC_BL8_EXTRA   = 3'h6;   // back to nominal at off latency + 6
  localparam int TSC_CLK_PERIOD_PS  = 10000;       // 100 mhz
  localparam int TSC_ASYNC_MIN_PS   = 2000;        // 2 ns
  localparam int TSC_ASYNC_MAX_PS   = 8500;        // 8.5 ns
  localparam int TSC_ASYNC_MIN_CYC_RAW = (TSC_ASYNC_MIN_PS + TSC_CLK_PERIOD_PS - 1) / TSC_CLK_PERIOD_PS;
  localparam int TSC_ASYNC_MAX_CYC_RAW = TSC_ASYNC_MAX_PS / TSC_CLK_PERIOD_PS;
  localparam int TSC_ASYNC_MIN_CYC = (TSC_ASYNC_MIN_CYC_RAW < 1) ? 1 : TSC_ASYNC_MIN_CYC_RAW;
  localparam int TSC_ASYNC_MAX_CYC = (TSC_ASYNC_MAX_CYC_RAW < 1) ? 1 : TSC_ASYNC_MAX_CYC_RAW;

endpackage : tsc_pkg

// ### design/tsc_delay_line.sv
// tapped delay line holding the recent history of the pin and command samples
`timescale 1ns/1ps
module tsc_delay_line #(
  parameter int W     = 3,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          ce,
  // sample in, tapped sample out
  input  wire logic [W-1:0]  din,
  input  wire logic [AW-1:0] tap,
  output logic      [W-1:0]  dout
);

  logic [W-1:0] line [DEPTH];  // line[k] holds the sample taken k edges ago

  // ----------------------------------------------------------------
  // shift and registered read
  // ----------------------------------------------------------------
  // read data come from a flip-flop, so a tap of k gives a total delay of k+1 edges
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        line[i] <= '0;
      end
      dout <= '0;
    end else if (ce) begin
      line[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        line[i] <= line[i-1];
      end
      dout <= line[tap];
    end
  end

endmodule : tsc_delay_line

// ### design/tsc_termination.sv
// termination strength control: odt pin latency, dynamic write strength, async power-down path
// What this block does
// - dynamic switching on when either write bit set
// - nominal code from mode1 bits a9,a6,a2
// - write code from mode2 bits a10,a9
// - no write: nominal strength, pin drives switch
// - write strength at wl-2 after any write
// - chop4 write: nominal again at off+4
// - bl8 write: nominal again at off+6
// - switch on/off wl-2 after pin registered
// - changes land half a cycle after count
// - async only in power-down with frozen dll
// - async path skips both write and additive latency
// - async change within 2 to 8.5 ns
// - odt live in power-down, no commands there
// - sync latency is cwl + al - 2
// - pin ignored when disabled or self-refresh
`timescale 1ns/1ps
module tsc_termination
  import tsc_pkg::*;
#(
  parameter int DEPTH = 32,  // longest supported on/off latency
  parameter int AW    = 5
) (
  // clock, reset, enable
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // memory-side pins and states
  input  wire logic        odt_pin,
  input  wire logic        wr_cmd,
  input  wire logic        wr_chop4,
  input  wire logic        pd_active,
  input  wire logic        self_refresh,
  // termination drive
  output logic             term_on,
  output logic             term_write_sel,
  output logic      [2:0]  term_code
);

  // ----------------------------------------------------------------
  // configuration state
  // ----------------------------------------------------------------
  logic        pd_dll_on;  // mode0 a12 copy
  logic [2:0]  rtt_nom;    // mode1 nominal code
  logic [1:0]  rtt_wr;     // mode2 write code
  logic [4:0]  cwl;        // write latency without additive part
  logic [4:0]  al;         // additive latency
  logic        wr_pend;    // data phase of a write is open
  logic [7:0]  wr_addr;    // address of that write

  // ----------------------------------------------------------------
  // datapath state
  // ----------------------------------------------------------------
  logic        odt_q;      // pin as registered at the last edge
  logic [2:0]  dl_out;     // {odt, write, chop4} delayed by the on/off latency
  logic [2:0]  wcnt;       // remaining cycles of write strength
  logic        term_int;   // switch state on the rising-edge side
  logic        wstr_int;   // strength state on the rising-edge side

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  // tap index for an on/off latency of cwl + al - 2, clamped to the line
  function automatic logic [AW-1:0] lat_tap(input logic [4:0] c, input logic [4:0] a);
    logic [5:0] lat;
    lat = 6'({1'b0, c} + {1'b0, a} - TSC_LAT_OFFSET);
    if (lat == 6'h00) begin
      lat_tap = '0;
    end else if (int'(lat) > DEPTH) begin
      lat_tap = AW'(DEPTH - 1);
    end else begin
      lat_tap = AW'(lat - 6'h01);
    end
  endfunction : lat_tap

  // applied strength code: zero while the switch is off
  function automatic logic [2:0] applied_code(input logic on, input logic wsel,
                                              input logic [2:0] nom, input logic [1:0] wr);
    if (!on) begin
      applied_code = 3'h0;
    end else if (wsel) begin
      applied_code = {1'b0, wr};
    end else begin
      applied_code = nom;
    end
  endfunction : applied_code

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        addr_phase = hsel & htrans[1] & hready;
  wire        do_write   = wr_pend & hready;
  wire [7:0]  rd_addr    = haddr[7:0];

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  wire dyn_en     = (rtt_wr != 2'h0);
  wire term_en    = ((rtt_nom != 3'h0) | (rtt_wr != 2'h0)) & ~self_refresh;
  wire async_mode = pd_active & ~pd_dll_on;
  // commands are not decoded in power-down or self-refresh
  wire wr_accept  = wr_cmd & ~pd_active & ~self_refresh;
  wire [AW-1:0] tap = lat_tap(cwl, al);
  wire dl_odt     = dl_out[2];
  wire dl_wr      = dl_out[1] & dyn_en;
  wire dl_chop4   = dl_out[0];
  // read mux sits below the mode decode because the status word shows it
  wire [31:0] status_word = {25'h0, applied_code(term_int, wstr_int, rtt_nom, rtt_wr), dyn_en, async_mode,
                             wstr_int, term_int};
  wire [31:0] rd_word =
    (rd_addr == TSC_REG_MODE0)  ? {31'h0, pd_dll_on} :
    (rd_addr == TSC_REG_MODE1)  ? {29'h0, rtt_nom} :
    (rd_addr == TSC_REG_MODE2)  ? {30'h0, rtt_wr} :
    (rd_addr == TSC_REG_LAT)    ? {19'h0, al, 3'h0, cwl} :
    (rd_addr == TSC_REG_STATUS) ? status_word : 32'h0;  // unmapped reads as zero

  // ----------------------------------------------------------------
  // next termination state
  // ----------------------------------------------------------------
  // async path uses the raw sample: no on/off latency in power-down with the dll frozen
  wire sw_on      = async_mode ? odt_q : dl_odt;
  wire next_term  = term_en & sw_on;
  // a write can only pick the strength; the pin still decides on/off
  wire next_wstr  = ~async_mode & dyn_en & (dl_wr | (wcnt != 3'h0));
  wire [2:0] next_wcnt =
    dl_wr    ? (dl_chop4 ? TSC_CHOP4_EXTRA - 3'h1 : TSC_BL8_EXTRA - 3'h1) :
    (wcnt != 3'h0) ? wcnt - 3'h1 : 3'h0;

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  // zero wait states: read data are registered in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h0;
    end else if (ce) begin
      wr_pend <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr <= rd_addr;
      end
      if (addr_phase & ~hwrite) begin
        hrdata <= rd_word;
      end
    end
  end

  // configuration writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pd_dll_on <= TSC_RST_PD_DLL;
      rtt_nom   <= TSC_RST_NOM;
      rtt_wr    <= TSC_RST_WR;
      cwl       <= TSC_RST_CWL;
      al        <= TSC_RST_AL;
    end else if (ce && do_write) begin
      if (wr_addr == TSC_REG_MODE0) begin
        pd_dll_on <= hwdata[TSC_PD_DLL_BIT];
      end
      if (wr_addr == TSC_REG_MODE1) begin
        rtt_nom <= hwdata[TSC_NOM_LSB +: TSC_NOM_W];
      end
      if (wr_addr == TSC_REG_MODE2) begin
        rtt_wr <= hwdata[TSC_WR_LSB +: TSC_WR_W];
      end
      if (wr_addr == TSC_REG_LAT) begin
        cwl <= hwdata[TSC_CWL_LSB +: TSC_LAT_W];
        al  <= hwdata[TSC_AL_LSB +: TSC_LAT_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // latency line for pin and write commands
  // ----------------------------------------------------------------
  tsc_delay_line #(
    .W     (3),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_line (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .din     ({odt_pin, wr_accept, wr_chop4}),
    .tap     (tap),
    .dout    (dl_out)
  );

  // ----------------------------------------------------------------
  // rising-edge termination state
  // ----------------------------------------------------------------
  // a new write reloads the counter, so back-to-back writes extend the strength
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      odt_q    <= 1'b0;
      wcnt     <= 3'h0;
      term_int <= 1'b0;
      wstr_int <= 1'b0;
    end else if (ce) begin
      odt_q    <= odt_pin;
      wcnt     <= next_wcnt;
      term_int <= next_term;
      wstr_int <= next_wstr;
    end
  end

  // ----------------------------------------------------------------
  // falling-edge output stage
  // ----------------------------------------------------------------
  // retiming on the falling edge adds the nominal half cycle; in async mode it
  // also puts the change 5 ns after the sampling edge, inside the 2 to 8.5 ns window
  always_ff @(negedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      term_on        <= 1'b0;
      term_write_sel <= 1'b0;
      term_code      <= 3'h0;
    end else if (ce) begin
      term_on        <= next_term;
      term_write_sel <= next_wstr;
      term_code      <= applied_code(next_term, next_wstr, rtt_nom, rtt_wr);
    end
  end

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  logic [DEPTH:0] pin_hist;  // pin_hist[k]: pin sampled k edges ago
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_hist <= '0;
    end else if (ce) begin
      pin_hist <= {pin_hist[DEPTH-1:0], odt_pin};
    end
  end
  wire [5:0] lat_now = 6'({1'b0, cwl} + {1'b0, al} - TSC_LAT_OFFSET);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_dyn_gate;
    @(posedge hclk) disable iff (!hresetn)
    (ce && term_write_sel) |-> (rtt_wr != 2'h0);
  endproperty
  a_dyn_gate: assert property (p_dyn_gate) else $error("write strength while dynamic switching off");

  property p_nom_code;
    @(posedge hclk) disable iff (!hresetn)
    (ce && term_on && !term_write_sel) |-> (term_code == rtt_nom);
  endproperty
  a_nom_code: assert property (p_nom_code) else $error("nominal code not applied");

  property p_wr_code;
    @(posedge hclk) disable iff (!hresetn)
    (ce && term_on && term_write_sel) |-> (term_code == {1'b0, rtt_wr});
  endproperty
  a_wr_code: assert property (p_wr_code) else $error("write code not applied");

  property p_sync_latency;
    @(posedge hclk) disable iff (!hresetn)
    (ce && !async_mode && term_en && lat_now >= 6'h01 && int'(lat_now) <= DEPTH && $stable(lat_now))
      |-> (sw_on == pin_hist[lat_now]);
  endproperty
  a_sync_latency: assert property (p_sync_latency) else $error("sync on/off latency wrong");

  property p_write_start;
    @(posedge hclk) disable iff (!hresetn)
    (ce && dl_wr && !async_mode) |-> next_wstr ##1 (!ce || wcnt != 3'h0);
  endproperty
  a_write_start: assert property (p_write_start) else $error("write strength not selected");

  property p_chop4_len;
    @(posedge hclk) disable iff (!hresetn)
    (ce && dl_wr && dl_chop4) |=> (!ce || wcnt == 3'h3);
  endproperty
  a_chop4_len: assert property (p_chop4_len) else $error("chop4 write strength length wrong");

  property p_bl8_len;
    @(posedge hclk) disable iff (!hresetn)
    (ce && dl_wr && !dl_chop4) |=> (!ce || wcnt == 3'h5);
  endproperty
  a_bl8_len: assert property (p_bl8_len) else $error("bl8 write strength length wrong");

  property p_half_cycle;
    @(posedge hclk) disable iff (!hresetn)
    (ce && $past(ce)) |-> (term_int == $past(term_on) && wstr_int == $past(term_write_sel));
  endproperty
  a_half_cycle: assert property (p_half_cycle) else $error("output stage out of step");

  property p_async_follow;
    @(posedge hclk) disable iff (!hresetn)
    (ce && async_mode && term_en && odt_pin) ##1 (ce && async_mode && term_en) |-> next_term;
  endproperty
  a_async_follow: assert property (p_async_follow) else $error("async turn-on too slow");

  property p_no_cmd_pd;
    @(posedge hclk) disable iff (!hresetn)
    pd_active |-> !wr_accept;
  endproperty
  a_no_cmd_pd: assert property (p_no_cmd_pd) else $error("command taken in power-down");

  property p_sr_off;
    @(posedge hclk) disable iff (!hresetn)
    (ce && self_refresh) |=> (!ce || !term_int);
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("termination on in self-refresh");

  c_chop4: cover property (@(posedge hclk) disable iff (!hresetn) dl_wr && dl_chop4 && term_en);
  c_bl8:   cover property (@(posedge hclk) disable iff (!hresetn) dl_wr && !dl_chop4 && term_en);
  c_async: cover property (@(posedge hclk) disable iff (!hresetn) async_mode && term_int);

endmodule : tsc_termination

// ### test/tsc_ctrl_model.sv
// controller-side model driving the termination pin and write commands
`timescale 1ns/1ps
module tsc_ctrl_model (
  // clock and power state
  input  wire logic hclk,
  input  wire logic pd_active,
  // pins towards the device
  output logic      odt_pin,
  output logic      wr_cmd,
  output logic      wr_chop4
);
  // ------------------------------------------------------------
  // idle levels: the controller always drives its pins
  // ------------------------------------------------------------
  initial begin
    odt_pin  = 1'b0;
    wr_cmd   = 1'b0;
    wr_chop4 = 1'b0;
  end

  // one pin window of hi cycles, stretched to at least 4 and over the write strength, with nw writes from cycle wpos
  // hi of 0 sends the writes with the pin low
  task automatic burst(input int hi, input int wpos, input int nw, input bit c4);
    int len;
    int ext;
    len = wpos + nw + 1;
    ext = wpos + nw - 1 + (c4 ? 4 : 6);
    if (hi > 0 && hi < 4) hi = 4;
    if (hi > 0 && nw > 0 && hi < ext) hi = ext;
    if (hi > len) len = hi;
    for (int i = 0; i <= len; i++) begin
      @(posedge hclk);
      odt_pin  <= (i < hi);
      // no commands reach a device in power-down
      wr_cmd   <= (i >= wpos) && (i < wpos + nw) && !pd_active;
      wr_chop4 <= c4;
    end
  endtask : burst
endmodule : tsc_ctrl_model

// ### test/test_termination_strength_control.sv
// self-checking bench for the termination strength control block
`timescale 1ns/1ps
module test_termination_strength_control;
  import tsc_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        hclk, hresetn, ce, hsel, hwrite, pd_active, self_refresh;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize, term_code;
  logic        hreadyout, hresp, term_on, term_write_sel, odt_pin, wr_cmd, wr_chop4;
  int          fail_count, total_checks, chk_on;
  int          m_nom, m_wr, m_cwl, m_al, m_dll;  // model copy of the settings
  int          oh[$];                           // pin level at every edge
  int          wq[$];                           // write-strength cycles of the write taken at every edge (4 chop4, 6 bl8), 0 for none

  tsc_termination #(.DEPTH(32), .AW(5)) uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .odt_pin(odt_pin), .wr_cmd(wr_cmd), .wr_chop4(wr_chop4), .pd_active(pd_active),
    .self_refresh(self_refresh), .term_on(term_on), .term_write_sel(term_write_sel),
    .term_code(term_code));

  tsc_ctrl_model ctl (.hclk(hclk), .pd_active(pd_active), .odt_pin(odt_pin),
    .wr_cmd(wr_cmd), .wr_chop4(wr_chop4));

  // ------------------------------------------------------------
  // clock and watchdog
  // ------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // generous against the few thousand cycles the tests need
  initial begin
    #500000;
    fail_count++;
    complete_run();
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  // single word transfer; called just after a rising edge
  task automatic ahb(input bit w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    if (n >= 50) fail_count++;
    r = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask : ahb

  // ------------------------------------------------------------
  // reference model: expected state after every rising edge
  // ------------------------------------------------------------
  always @(posedge hclk) begin
    int k, lat, ws, on, cd;
    oh.push_back(odt_pin === 1'b1);
    wq.push_back((wr_cmd === 1'b1 && !pd_active && !self_refresh) ? ((wr_chop4 === 1'b1) ? 4 : 6) : 0);
    k = oh.size() - 1;
    lat = m_cwl + m_al - 2;
    if (lat < 1) lat = 1;
    if (lat > 32) lat = 32;
    // frozen dll in power-down skips the latency pipe
    if (pd_active && !m_dll) lat = 0;
    on = ((m_nom | m_wr) != 0) && !self_refresh && k >= lat && oh[k - lat] != 0;
    // the newest write through the latency decides: a newer one restarts the count
    ws = 0;
    if (m_wr != 0 && !(pd_active && !m_dll)) begin
      for (int j = k - lat; j >= 0 && j > k - lat - 6; j--) begin
        if (wq[j] != 0) begin
          ws = (k - j - lat) < wq[j];
          break;
        end
      end
    end
    cd = on ? (ws ? m_wr : m_nom) : 0;
    #7;  // outputs move on the falling edge
    if (chk_on) begin
      check("term_on", 32'(term_on), 32'(on));
      check("term_write_sel", 32'(term_write_sel), 32'(ws));
      check("term_code", 32'(term_code), 32'(cd));
    end
  end

  // reprogram with the pin quiet, then check the status flags
  task automatic cfg(input int nom, wr, cwl, al, dll, pd, sr);
    chk_on = 0;
    ahb(1, TSC_REG_MODE1, nom, q);
    ahb(1, TSC_REG_MODE2, wr, q);
    ahb(1, TSC_REG_LAT, (al << 8) | cwl, q);
    ahb(1, TSC_REG_MODE0, dll, q);
    pd_active    <= pd;
    self_refresh <= sr;
    {m_nom, m_wr, m_cwl, m_al, m_dll} = {nom, wr, cwl, al, dll};
    repeat (40) @(posedge hclk);
    ahb(0, TSC_REG_STATUS, 0, q);
    check("status_dyn", 32'(q[3]), 32'(wr != 0));
    check("status_async", 32'(q[2]), 32'(pd && !dll));
    check("status_idle", 32'({q[6:4], q[1:0]}), 32'h0);
    chk_on = 1;
  endtask : cfg

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {hresetn, hsel, hwrite, pd_active, self_refresh, htrans} = '0;
    {haddr, hwdata, chk_on} = '0;
    ce    = 1'b1;
    hsize = 3'h2;
    {m_nom, m_wr, m_cwl, m_al, m_dll} = {0, 0, 5, 0, 0};
    void'($urandom(32'h33b368bb));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // reset values, unmapped place, read-only status
    ahb(0, TSC_REG_MODE0, 0, q); check("mode0", q, 32'h0);
    ahb(0, TSC_REG_MODE1, 0, q); check("mode1", q, 32'h0);
    ahb(0, TSC_REG_MODE2, 0, q); check("mode2", q, 32'h0);
    ahb(0, TSC_REG_LAT, 0, q);   check("lat", q, 32'h5);
    ahb(1, 8'h20, 32'hffff_ffff, q);
    ahb(0, 8'h20, 0, q);         check("unmapped", q, 32'h0);
    ahb(1, TSC_REG_STATUS, 32'hff, q);
    ahb(0, TSC_REG_STATUS, 0, q); check("status_ro", q, 32'h0);
    chk_on = 1;
    // random strengths and latencies around every kind of write
    for (int i = 0; i < 24; i++) begin
      cfg(1 + $urandom % 7, $urandom % 4, 5 + $urandom % 6, $urandom % 5, 1, 0, 0);
      ctl.burst(4, 0, 1, 1);                        // chop4 at the shortest hold
      ctl.burst(6, 0, 1, 0);                        // bl8 at the shortest hold
      repeat ($urandom % 16) @(posedge hclk);
      ctl.burst(8, 2, 2, $urandom % 2);             // back to back writes
      ctl.burst(0, 1, 1, $urandom % 2);             // write with the pin low
      ctl.burst(4 + $urandom % 6, 0, 0, 0);         // pin alone
      repeat (20) @(posedge hclk);
    end
    // clock enable low freezes everything: pin and write must not be taken
    chk_on = 0;
    ce <= 1'b0;
    fork
      ctl.burst(6, 0, 1, 0);
      repeat (20) begin
        @(posedge hclk);
        #7;
        check("frozen_on", 32'(term_on), 32'h0);
        check("frozen_wsel", 32'(term_write_sel), 32'h0);
      end
    join
    @(posedge hclk);
    ce <= 1'b1;
    // both codes zero, then self-refresh: pin ignored
    cfg(0, 0, 5, 0, 1, 0, 0);
    ctl.burst(6, 0, 1, 0);
    cfg(3, 1, 5, 0, 1, 0, 1);
    ctl.burst(6, 0, 1, 0);
    // power-down with dll kept on stays synchronous
    cfg(5, 2, 6, 3, 1, 1, 0);
    ctl.burst(5, 0, 0, 0);
    // write strength cleared before freezing the dll
    cfg(5, 0, 6, 3, 0, 1, 0);
    for (int i = 0; i < 8; i++) begin
      ctl.burst(4 + $urandom % 5, 0, 1, 0);
      repeat ($urandom % 4) @(posedge hclk);
    end
    cfg(0, 0, 5, 0, 1, 0, 0);
    complete_run();
  end
endmodule : test_termination_strength_control
